// *** hdl/cap_cmp_array.sv ***
// Capture/compare array: shared counter, register port and five module instances
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module cap_cmp_array import cap_cmp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Module pins
  input wire logic [num_modules-1:0] pin_in,
  output logic [num_modules-1:0] pin_out,
  output logic [num_modules-1:0] pin_oe,
  // System outputs
  output logic irq,
  output logic wdog_reset
);
  bus_req_t req;
  logic [15:0] count_q, count_d;
  logic run_q, run_d, ovf_q, ovf_d, rst_en_q, rst_en_d, ovf_irq_q, ovf_irq_d;
  logic [7:0] rdata_d;
  logic irq_d, wrst_d, wrap;
  logic [num_modules-1:0] sync1_q, sync2_q, oe_d;
  logic [num_modules-1:0] flag, mout, ireq, whit, mwe, lwe, hwe, fclr;
  logic [7:0] mode_r [num_modules];
  logic [7:0] low_r [num_modules];
  logic [7:0] high_r [num_modules];

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign wrap = run_q && (count_q[7:0] == 8'hff);

  // Pin synchroniser, two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in; // [RULE_21]
      sync2_q <= sync1_q; // [RULE_21]
    end
  end

  // Module instances and their write decodes
  genvar g;
  generate
    for (g = 0; g < num_modules; g++) begin : gen_mod
      assign mwe[g] = req.wr && (req.addr == off_mode_base + 8'(g));
      assign lwe[g] = req.wr && (req.addr == off_low_base + 8'(g));
      assign hwe[g] = req.wr && (req.addr == off_high_base + 8'(g));
      assign fclr[g] = req.wr && (req.addr == off_ctrl_status) && !req.wdata[g];
      cap_cmp_module #(.has_wdog(g == wdog_module)) u_mod ( // [RULE_22]
        .clk(clk),
        .rst_n(rst_n),
        .count(count_q),
        .count_wrap(wrap),
        .pin_sync(sync2_q[g]),
        .mode_we(mwe[g]),
        .low_we(lwe[g]),
        .high_we(hwe[g]),
        .flag_clr(fclr[g]),
        .wdata(req.wdata),
        .mode_q(mode_r[g]),
        .low_q(low_r[g]),
        .high_q(high_r[g]),
        .flag_q(flag[g]),
        .pin_out_q(mout[g]),
        .wdog_hit(whit[g]),
        .irq_req(ireq[g])
      );
      assign oe_d[g] = mode_r[g][bit_cmp_en] && (mode_r[g][bit_pwm_en] || mode_r[g][bit_invert]);
    end
  endgenerate

  // Counter, control bits and read mux
  always_comb begin
    count_d = count_q;
    run_d = run_q;
    ovf_d = ovf_q;
    rst_en_d = rst_en_q;
    ovf_irq_d = ovf_irq_q;
    rdata_d = 8'h00;
    if (req.wr && req.addr == off_ctrl_status) begin
      run_d = req.wdata[bit_counter_run];
      if (!req.wdata[bit_overflow_flag]) begin
        ovf_d = 1'b0;
      end
    end
    if (req.wr && req.addr == off_array_mode) begin
      rst_en_d = req.wdata[bit_reset_out_en];
      ovf_irq_d = req.wdata[0];
    end
    if (req.wr && req.addr == off_counter_low) begin
      count_d[7:0] = req.wdata;
    end
    if (req.wr && req.addr == off_counter_high) begin
      count_d[15:8] = req.wdata;
    end
    if (run_q) begin
      count_d = count_q + 16'h0001; // [RULE_17] [RULE_18]
      if (count_q == 16'hffff) begin
        ovf_d = 1'b1;
      end
    end
    if (req.rd) begin
      case (req.addr)
        off_ctrl_status: rdata_d = {ovf_q, run_q, 1'b0, flag};
        off_array_mode: rdata_d = {1'b0, rst_en_q, 5'h00, ovf_irq_q};
        off_counter_low: rdata_d = count_q[7:0];
        off_counter_high: rdata_d = count_q[15:8];
        default: begin
          for (int i = 0; i < num_modules; i++) begin
            if (req.addr == off_mode_base + 8'(i)) rdata_d = mode_r[i];
            if (req.addr == off_low_base + 8'(i)) rdata_d = low_r[i];
            if (req.addr == off_high_base + 8'(i)) rdata_d = high_r[i];
          end
        end
      endcase
    end
    irq_d = (|ireq) || (ovf_q && ovf_irq_q); // [RULE_13]
    wrst_d = whit[wdog_module] && rst_en_q; // [RULE_06]
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= rst_count;
      run_q <= 1'b0;
      ovf_q <= 1'b0;
      rst_en_q <= 1'b0;
      ovf_irq_q <= 1'b0;
      rdata <= 8'h00;
      irq <= 1'b0;
      wdog_reset <= 1'b0;
      pin_out <= '1;
      pin_oe <= '0;
    end else begin
      count_q <= count_d;
      run_q <= run_d;
      ovf_q <= ovf_d;
      rst_en_q <= rst_en_d;
      ovf_irq_q <= ovf_irq_d;
      rdata <= rdata_d;
      irq <= irq_d;
      wdog_reset <= wrst_d;
      pin_out <= mout;
      pin_oe <= oe_d;
    end
  end

  chk_counter_stop: assert property (@(posedge clk) disable iff (!rst_n)
    (!run_q && !req.wr) |=> count_q == $past(count_q)) else $error("counter moved while stopped"); // [RULE_18]
  chk_counter_step: assert property (@(posedge clk) disable iff (!rst_n)
    run_q |=> count_q == $past(count_q) + 16'h0001) else $error("counter did not advance"); // [RULE_17]
  chk_wdog_gate: assert property (@(posedge clk) disable iff (!rst_n)
    wdog_reset |-> $past(rst_en_q)) else $error("reset without enable"); // [RULE_06]
  cov_wdog: cover property (@(posedge clk) disable iff (!rst_n) wdog_reset);
endmodule
`default_nettype wire

// *** hdl/cap_cmp_module.sv ***
// One capture/compare module: mode decode, pin capture, compare, pulse width and event flag
`timescale 1ns/100ps
`default_nettype none
module cap_cmp_module import cap_cmp_pkg::*; #(
  parameter bit has_wdog = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Shared counter
  input wire logic [15:0] count,
  input wire logic count_wrap,
  // Synchronised pin level
  input wire logic pin_sync,
  // Software access
  input wire logic mode_we,
  input wire logic low_we,
  input wire logic high_we,
  input wire logic flag_clr,
  input wire logic [7:0] wdata,
  // State
  output logic [7:0] mode_q,
  output logic [7:0] low_q,
  output logic [7:0] high_q,
  output logic flag_q,
  output logic pin_out_q,
  output logic wdog_hit,
  output logic irq_req
);
  logic [7:0] mode_d, low_d, high_d;
  logic flag_d, pin_out_d, prev_q, prev_d, cmp_hold_q, cmp_hold_d;
  logic rise, fall, cap_ev, hit_ev;
  func_t fn;

  // Decode and event detection
  always_comb begin
    fn = decode_mode(mode_q, has_wdog); // [RULE_04] [RULE_05] [RULE_22]
    rise = pin_sync && !prev_q; // [RULE_21]
    fall = !pin_sync && prev_q; // [RULE_21]
    cap_ev = (fn == fn_cap) && ((rise && mode_q[bit_rise_en]) || (fall && mode_q[bit_fall_en])); // [RULE_01] [RULE_02] [RULE_03] [RULE_16]
    hit_ev = (fn == fn_timer || fn == fn_hso || fn == fn_wdog) && !cmp_hold_q && (count == {high_q, low_q});
  end

  // Next-state logic
  always_comb begin
    mode_d = mode_q;
    low_d = low_q;
    high_d = high_q;
    flag_d = flag_q;
    pin_out_d = pin_out_q;
    prev_d = pin_sync;
    cmp_hold_d = cmp_hold_q;
    if (mode_we) begin
      mode_d = {1'b0, wdata[6:0]}; // [RULE_11]
    end
    if (low_we) begin
      low_d = wdata;
      cmp_hold_d = 1'b1; // Low byte write holds off compare until high byte
    end
    if (high_we) begin
      high_d = wdata;
      cmp_hold_d = 1'b0;
    end
    if (cap_ev) begin
      high_d = count[15:8]; // [RULE_12] [RULE_14]
      low_d = count[7:0]; // [RULE_12] [RULE_14]
    end
    if (fn == fn_pwm && count_wrap) begin
      low_d = high_q; // Duty value reloads at period start
    end
    if (flag_clr) begin
      flag_d = 1'b0; // [RULE_15]
    end
    if (cap_ev || hit_ev) begin
      flag_d = 1'b1; // [RULE_15] [RULE_19]
    end
    if (fn == fn_pwm) begin
      pin_out_d = (count[7:0] >= low_q); // [RULE_20] [RULE_08]
    end else if (hit_ev && mode_q[bit_invert] && (fn == fn_hso || fn == fn_wdog)) begin
      pin_out_d = !pin_out_q; // [RULE_07]
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= rst_mode;
      low_q <= rst_byte;
      high_q <= rst_byte;
      flag_q <= 1'b0;
      pin_out_q <= 1'b1;
      prev_q <= 1'b0;
      cmp_hold_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      low_q <= low_d;
      high_q <= high_d;
      flag_q <= flag_d;
      pin_out_q <= pin_out_d;
      prev_q <= prev_d;
      cmp_hold_q <= cmp_hold_d;
    end
  end

  assign wdog_hit = hit_ev && (fn == fn_wdog); // [RULE_06]
  assign irq_req = flag_q && mode_q[bit_irq_en]; // [RULE_13]

  chk_capture_loads: assert property (@(posedge clk) disable iff (!rst_n)
    cap_ev |=> ({high_q, low_q} == $past(count))) else $error("capture did not load counter"); // [RULE_12]
  chk_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    (cap_ev || hit_ev) |=> flag_q) else $error("event flag not set"); // [RULE_15]
  chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == 8'h00) |-> !cap_ev && !hit_ev) else $error("idle module active"); // [RULE_16]
  chk_rise_only: assert property (@(posedge clk) disable iff (!rst_n)
    (fn == fn_cap && !mode_q[bit_fall_en] && fall) |-> !cap_ev) else $error("fall captured in rise mode"); // [RULE_01]
  chk_fall_only: assert property (@(posedge clk) disable iff (!rst_n)
    (fn == fn_cap && !mode_q[bit_rise_en] && rise) |-> !cap_ev) else $error("rise captured in fall mode"); // [RULE_02]
  chk_both_edges: assert property (@(posedge clk) disable iff (!rst_n)
    (fn == fn_cap && mode_q[bit_rise_en] && mode_q[bit_fall_en] && (rise || fall)) |-> cap_ev)
    else $error("edge missed in both mode"); // [RULE_03]
  chk_pwm_level: assert property (@(posedge clk) disable iff (!rst_n)
    (fn == fn_pwm && $past(fn == fn_pwm)) |-> pin_out_q == ($past(count[7:0]) >= $past(low_q)))
    else $error("pulse width level wrong"); // [RULE_20]
  chk_wdog_only4: assert property (@(posedge clk) disable iff (!rst_n)
    !has_wdog |-> !wdog_hit) else $error("watchdog outside module four"); // [RULE_05]
  chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (cap_ev && mode_q[bit_irq_en] && !mode_we) |=> irq_req) else $error("capture raised no interrupt"); // [RULE_13]
  cov_capture: cover property (@(posedge clk) disable iff (!rst_n) cap_ev);
  cov_hit: cover property (@(posedge clk) disable iff (!rst_n) hit_ev);
  cov_pwm: cover property (@(posedge clk) disable iff (!rst_n) fn == fn_pwm ##1 $rose(pin_out_q));
endmodule
`default_nettype wire

// *** inc/cap_cmp_pkg.sv ***
// Package: register map, field positions, reset values and carriers for the capture/compare array
// Overview of operation
// (RULE_01) Rise-only enable captures on rising pin edges
// (RULE_02) Fall-only enable captures on falling pin edges
// (RULE_03) Both enables capture on every pin transition
// (RULE_04) Decode timer, toggle output and pulse-width modes
// (RULE_05) Watchdog compare exists only in module four
// (RULE_06) Watchdog reset output needs reset output enable
// (RULE_07) Watchdog toggles pin only when invert set
// (RULE_08) Pulse-width output ignores module interrupt enable
// (RULE_09) Software keeps interrupt off for watchdog
// (RULE_10) Software writes zero to reserved mode bit
// (RULE_11) Reserved mode bit read value is undefined
// (RULE_12) Capture loads full counter into capture registers
// (RULE_13) Interrupt when event flag and enable set
// (RULE_14) Later capture overwrites earlier, no overrun guard
// (RULE_15) Hardware sets event flag, software write clears
// (RULE_16) All-zero mode field means no activity
// (RULE_17) Shared free-running sixteen-bit counter, high/low bytes
// (RULE_18) Counter advances only while run bit set
// (RULE_19) Event flag set on match and capture
// (RULE_20) Pulse-width pin low while counter low below compare
// (RULE_21) Pins synchronised, then edge-detected on sampled levels
// (RULE_22) Five identical modules, watchdog only in module four
package cap_cmp_pkg;
  localparam int unsigned num_modules = 5;
  localparam int unsigned wdog_module = 4;
  localparam int unsigned addr_w = 8;
  // Register offsets
  localparam logic [7:0] off_ctrl_status = 8'hd8;
  localparam logic [7:0] off_array_mode = 8'hd9;
  localparam logic [7:0] off_counter_low = 8'he9;
  localparam logic [7:0] off_counter_high = 8'hf9;
  localparam logic [7:0] off_mode_base = 8'hda;
  localparam logic [7:0] off_low_base = 8'hea;
  localparam logic [7:0] off_high_base = 8'hfa;
  // Mode control field positions
  localparam int unsigned bit_irq_en = 0;
  localparam int unsigned bit_pwm_en = 1;
  localparam int unsigned bit_invert = 2;
  localparam int unsigned bit_hit_en = 3;
  localparam int unsigned bit_fall_en = 4;
  localparam int unsigned bit_rise_en = 5;
  localparam int unsigned bit_cmp_en = 6;
  // Array control/status and array mode positions
  localparam int unsigned bit_counter_run = 6;
  localparam int unsigned bit_overflow_flag = 7;
  localparam int unsigned bit_reset_out_en = 6;
  // Reset values
  localparam logic [7:0] rst_mode = 8'h00;
  localparam logic [7:0] rst_byte = 8'h00;
  localparam logic [15:0] rst_count = 16'h0000;

  // Decoded module function
  typedef enum logic [6:0] {
    fn_idle = 7'h01,
    fn_cap = 7'h02,
    fn_timer = 7'h04,
    fn_hso = 7'h08,
    fn_pwm = 7'h10,
    fn_wdog = 7'h20,
    fn_other = 7'h40
  } func_t;

  // Register bus request carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // Module decode of a mode field
  function automatic func_t decode_mode(input logic [7:0] m, input logic wd_ok);
    logic [6:0] f;
    f = m[6:0] & 7'h7e;
    if (m[6:0] == 7'h00 || f == 7'h00) begin
      decode_mode = fn_idle;
    end else if (!m[bit_cmp_en] && (m[bit_rise_en] || m[bit_fall_en]) && !m[bit_hit_en] && !m[bit_pwm_en]) begin
      decode_mode = fn_cap;
    end else if (m[bit_cmp_en] && m[bit_pwm_en] && !m[bit_hit_en]) begin
      decode_mode = fn_pwm;
    end else if (m[bit_cmp_en] && m[bit_hit_en] && wd_ok) begin
      decode_mode = fn_wdog;
    end else if (m[bit_cmp_en] && m[bit_hit_en] && m[bit_invert]) begin
      decode_mode = fn_hso;
    end else if (m[bit_cmp_en] && m[bit_hit_en]) begin
      decode_mode = fn_timer;
    end else begin
      decode_mode = fn_other;
    end
  endfunction
endpackage

// *** tb/cap_cmp_array_bench.sv ***
// Self-checking bench for the capture/compare array
`timescale 1ns/100ps
`default_nettype none
module cap_cmp_array_bench import cap_cmp_pkg::*;;
  logic clk;
  logic rst_n;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, irq, wdog_reset;
  logic [num_modules-1:0] pin_in, pin_out, pin_oe, ext_lvl;
  int mismatches;
  int check_count;
  logic [15:0] cap_exp [num_modules];
  localparam logic [7:0] cap_modes [5] = '{8'h20, 8'h10, 8'h30, 8'h31, 8'h00};
  // Last entry runs the toggle output mode on an ordinary module
  localparam int wd_mod [5] = '{4, 4, 4, 0, 0};
  localparam logic [7:0] wd_mode [5] = '{8'h48, 8'h48, 8'h4c, 8'h48, 8'h4c};
  localparam bit wd_en [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  cap_cmp_array u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .wdog_reset(wdog_reset));
  pin_model u_pins (.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One register cycle; read data is taken in the cycle after the strobe
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input bit w, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, d, 1'b1, q);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] q);
    bus(a, 8'h00, 1'b0, q);
  endtask

  // Expected outcomes
  function automatic bit takes_edge(input logic [7:0] m, input bit rise);
    return !m[bit_cmp_en] && (rise ? m[bit_rise_en] : m[bit_fall_en]);
  endfunction

  function automatic int pwm_high(input logic [7:0] d);
    return 256 - int'(d);
  endfunction

  function automatic bit wd_fires(input int n, input bit en);
    return (n == wdog_module) && en;
  endfunction

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    #800000;
    mismatches++;
    $display("Error at %0t: run timed out", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    logic [7:0] q, m, d;
    logic [15:0] cnt;
    int n, hi, pulses;
    bit rise;
    logic p0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ext_lvl = '0;
    rst_n = 1'b0;
    void'($urandom(32'h70e7abe2));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and mode readback, reserved bit written as zero and not compared
    for (n = 0; n < num_modules; n++) begin
      cap_exp[n] = rst_count;
      rreg(8'(off_low_base + n), q);
      check({8'h00, q}, {8'h00, rst_byte}, "capture low at reset");
      m = 8'($urandom) & 8'h7f;
      wreg(8'(off_mode_base + n), m);
      rreg(8'(off_mode_base + n), q);
      check({8'h00, q & 8'h7f}, {8'h00, m}, "mode readback");
      wreg(8'(off_mode_base + n), 8'h00);
    end
    $display("Test reset and modes done");
    // Capture on selected pin edges, counter stopped at a known value
    for (int k = 0; k < 5; k++) begin
      m = cap_modes[k];
      n = $urandom % num_modules;
      wreg(8'(off_mode_base + n), m);
      repeat (2) begin
        wreg(off_ctrl_status, 8'h00);
        rreg(off_ctrl_status, q);
        check(16'(q[n]), 16'h0000, "flag cleared by write");
        cnt = 16'($urandom);
        wreg(off_counter_low, cnt[7:0]);
        wreg(off_counter_high, cnt[15:8]);
        rise = !ext_lvl[n];
        @(posedge clk);
        ext_lvl[n] <= rise;
        repeat (6) @(posedge clk);
        if (takes_edge(m, rise)) begin
          cap_exp[n] = cnt;
        end
        rreg(8'(off_low_base + n), q);
        check({8'h00, q}, {8'h00, cap_exp[n][7:0]}, "capture low");
        rreg(8'(off_high_base + n), q);
        check({8'h00, q}, {8'h00, cap_exp[n][15:8]}, "capture high");
        check(16'(irq), 16'(takes_edge(m, rise) && m[bit_irq_en]), "interrupt request");
        rreg(off_ctrl_status, q);
        check(16'(q[n]), 16'(takes_edge(m, rise)), "event flag");
      end
      wreg(8'(off_mode_base + n), 8'h00);
    end
    $display("Test capture done");
    // Pulse width output with and without the interrupt enable
    for (int k = 0; k < 2; k++) begin
      n = $urandom % num_modules;
      d = 8'($urandom % 255 + 1);
      wreg(off_ctrl_status, 8'h00);
      wreg(8'(off_low_base + n), d);
      wreg(8'(off_high_base + n), d);
      wreg(8'(off_mode_base + n), 8'h42 | 8'(k));
      wreg(off_ctrl_status, 8'h40);
      repeat (300) @(posedge clk);
      hi = 0;
      repeat (256) begin
        @(negedge clk);
        hi += int'(pin_out[n] === 1'b1);
      end
      check(16'(hi), 16'(pwm_high(d)), "pulse width high count");
      check(16'(pin_oe[n]), 16'h0001, "pulse width drive");
      wreg(8'(off_mode_base + n), 8'h00);
    end
    $display("Test pulse width done");
    // Watchdog compare: reset output, optional toggle, module four only
    for (int k = 0; k < 5; k++) begin
      n = wd_mod[k];
      wreg(off_ctrl_status, 8'h00);
      wreg(off_array_mode, wd_en[k] ? 8'h40 : 8'h00);
      cnt = 16'($urandom);
      wreg(off_counter_low, cnt[7:0]);
      wreg(off_counter_high, cnt[15:8]);
      cnt += 16'h0010;
      wreg(8'(off_low_base + n), cnt[7:0]);
      wreg(8'(off_high_base + n), cnt[15:8]);
      wreg(8'(off_mode_base + n), wd_mode[k]); // Interrupt enable left clear
      @(negedge clk);
      p0 = pin_out[n];
      wreg(off_ctrl_status, 8'h40);
      pulses = 0;
      repeat (60) begin
        @(negedge clk);
        pulses += int'(wdog_reset === 1'b1);
      end
      check(16'(pulses), 16'(wd_fires(n, wd_en[k])), "watchdog reset pulses");
      check(16'(pin_out[n]), 16'(p0 ^ wd_mode[k][bit_invert]), "pin after match");
      rreg(off_ctrl_status, q);
      check(16'(q[n]), 16'h0001, "flag on match");
      wreg(8'(off_mode_base + n), 8'h00);
      wreg(off_array_mode, 8'h00);
    end
    $display("Test watchdog done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** tb/pin_model.sv ***
// Pin-side partner: outside levels on the module pins, resolved against the array's own drive
`timescale 1ns/100ps
`default_nettype none
module pin_model import cap_cmp_pkg::*; (
  // Levels wanted by the outside world
  input wire logic [num_modules-1:0] ext_lvl,
  // Array's pin drive
  input wire logic [num_modules-1:0] pin_out,
  input wire logic [num_modules-1:0] pin_oe,
  // Resolved wire level
  output logic [num_modules-1:0] pin_in
);
  // The array wins wherever it drives; elsewhere the outside level stands
  always_comb begin
    for (int i = 0; i < num_modules; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
  end
endmodule
`default_nettype wire
